/* hw/gpcn_pkg.sv */
package gpcn_pkg;
    // default port width
    localparam int GPCN_WIDTH = 16;
    localparam int GPCN_ADDR_W = 8;
    // register offsets, one 16-byte group each: base, clear, set, invert
    localparam logic [7:0] OFF_ANALOG_SELECT = 8'h00;
    localparam logic [7:0] OFF_PIN_DIRECTION = 8'h10;
    localparam logic [7:0] OFF_PIN_LEVEL = 8'h20;
    localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h30;
    localparam logic [7:0] OFF_OPEN_DRAIN = 8'h40;
    localparam logic [7:0] OFF_PULLUP_EN = 8'h50;
    localparam logic [7:0] OFF_PULLDOWN_EN = 8'h60;
    localparam logic [7:0] OFF_CHANGE_CTRL = 8'h70;
    localparam logic [7:0] OFF_CHANGE_IRQ_EN = 8'h80;
    localparam logic [7:0] OFF_CHANGE_STATUS = 8'h90;
    localparam logic [7:0] OFF_REMAP_ENABLE = 8'hA0;
    // alias operation in address bits 3:2
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CLEAR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INVERT = 2'h3;
    // field positions
    localparam int CHANGE_CTRL_ON_BIT = 15;
    // values after reset, per bit
    localparam logic DIR_RST_BIT = 1'b1;
    localparam logic ANSEL_RST_BIT = 1'b1;
    localparam logic LATCH_RST_BIT = 1'b0;
    localparam logic CFG_RST_BIT = 1'b0;
    localparam logic REMAP_RST_BIT = 1'b0;
    localparam logic CHANGE_ON_RST = 1'b1;
    // cycles before change detection trusts the synchroniser after reset
    localparam logic [1:0] SYNC_PRIME_CYCLES = 2'h3;
    // axi answers
    localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
    localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;
endpackage : gpcn_pkg

/* hw/gpcn_sync_if.sv */
interface gpcn_sync_if #(
    parameter int W = 16
);
    logic [W-1:0] lvl;
    logic [W-1:0] chg;
    modport src (output lvl, output chg);
    modport dst (input lvl, input chg);
endinterface : gpcn_sync_if

/* hw/gpcn_sync.sv */
module gpcn_sync
    import gpcn_pkg::*;
#(
    parameter int W = GPCN_WIDTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] pins_i,
    gpcn_sync_if.src sync
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [1:0] prime_r;
    logic [1:0] prime_nxt;

    always_comb begin
        prime_nxt = (prime_r == SYNC_PRIME_CYCLES) ? prime_r : prime_r + 2'h1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            prime_r <= '0;
        end else begin
            s1_r <= pins_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            prime_r <= prime_nxt;
        end
    end

    // no clock gating here: detection keeps running while the core sleeps
    assign sync.lvl = s2_r;
    // masked until the chain holds real samples, avoids a false edge at reset
    assign sync.chg = (prime_r == SYNC_PRIME_CYCLES) ? (s2_r ^ s3_r) : '0;
endmodule : gpcn_sync

/* hw/gpcn_top.sv */
// Functional notes
// [RULE1] direction bit 1 input, 0 driven output
// [RULE2] reset makes every pin an input
// [RULE3] latch register reads and writes the latch
// [RULE4] level register reads pins, writes latch
// [RULE5] open-drain pins drive low only
// [RULE6] analog select resets to all ones
// [RULE7] software sets analog and direction for analog
// [RULE8] analog input pins read as zero
// [RULE9] output with analog select still drives digitally
// [RULE10] software waits one cycle before port readback
// [RULE11] enabled pin change raises interrupt request
// [RULE12] change detection runs during sleep
// [RULE13] change status since last level read
// [RULE14] separate weak pull-up and pull-down enables
// [RULE15] software disables pulls on digital outputs
// [RULE16] clear/set/invert alias touches only one bits
// [RULE17] alias reads undefined, result in base
// [RULE18] remapped peripheral has no default pin
// [RULE19] active remapped peripheral overrides digital functions
// [RULE20] remapped peripheral never overrides analog
// [RULE21] one request while status and enable set
module gpcn_top
    import gpcn_pkg::*;
#(
    parameter int W = GPCN_WIDTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [GPCN_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [GPCN_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [W-1:0] pin_in_i,
    output logic [W-1:0] pin_out_o,
    output logic [W-1:0] pin_oe_n_o,
    output logic [W-1:0] weak_pullup_en_o,
    output logic [W-1:0] weak_pulldown_en_o,
    input wire logic [W-1:0] remap_active_i,
    input wire logic [W-1:0] remap_out_i,
    input wire logic [W-1:0] remap_drive_i,
    output logic change_irq_o
);
    gpcn_sync_if #(.W(W)) sync ();
    gpcn_sync #(.W(W)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i(pin_in_i),
        .sync(sync.src)
    );
    function automatic logic [W-1:0] apply_op(input logic [W-1:0] old, input logic [1:0] op,
                                              input logic [W-1:0] val, input logic [W-1:0] m);
        logic [W-1:0] v;
        v = val & m;
        case (op)
            OP_CLEAR: apply_op = old & ~v;
            OP_SET: apply_op = old | v;
            OP_INVERT: apply_op = old ^ v;
            default: apply_op = (old & ~m) | v;
        endcase
    endfunction : apply_op
    // register file state
    logic [W-1:0] ansel_r, ansel_nxt, dir_r, dir_nxt, lat_r, lat_nxt, odc_r, odc_nxt;
    logic [W-1:0] pu_r, pu_nxt, pd_r, pd_nxt, cnen_r, cnen_nxt, cnstat_r, cnstat_nxt;
    logic [W-1:0] remap_en_r, remap_en_nxt;
    logic cn_on_r, cn_on_nxt;
    // bus state
    logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
    logic [GPCN_ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
    logic [W-1:0] wdata_r, wdata_nxt, wmask_r, wmask_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // pin state
    logic [W-1:0] pin_out_r, pin_out_nxt, oe_n_r, oe_n_nxt, gpio_oe_n, remap_use;
    logic irq_r, irq_nxt;
    logic aw_take, w_take, ar_take, wr_fire, wr_known, rd_known;
    logic [1:0] wr_op, rd_op;
    logic [W-1:0] pin_level, ana_in, wval, cl_val;
    logic [7:0] wr_base, rd_base;
    assign aw_take = s_axi_awvalid_i & awready_r;
    assign w_take = s_axi_wvalid_i & wready_r;
    assign ar_take = s_axi_arvalid_i & arready_r;
    assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
    assign wr_op = aw_addr_r[3:2];
    assign wr_base = {aw_addr_r[7:4], 4'h0};
    assign rd_op = s_axi_araddr_i[3:2];
    assign rd_base = {s_axi_araddr_i[7:4], 4'h0};
    assign wval = wdata_r;
    assign wr_known = (wr_base <= OFF_REMAP_ENABLE) && (aw_addr_r[1:0] == 2'h0);
    assign rd_known = (rd_base <= OFF_REMAP_ENABLE) && (s_axi_araddr_i[1:0] == 2'h0);
    // [RULE8] analog inputs read low
    assign ana_in = ansel_r & dir_r;
    // [RULE4] pins seen through the two-stage synchroniser
    assign pin_level = sync.lvl & ~ana_in;

    // bus handshake: one write and one read in flight
    always_comb begin
        aw_have_nxt = (aw_have_r | aw_take) & ~wr_fire;
        w_have_nxt = (w_have_r | w_take) & ~wr_fire;
        aw_addr_nxt = aw_take ? s_axi_awaddr_i : aw_addr_r;
        wdata_nxt = w_take ? s_axi_wdata_i[W-1:0] : wdata_r;
        wmask_nxt = wmask_r;
        if (w_take) begin
            for (int i = 0; i < W; i++) begin
                wmask_nxt[i] = s_axi_wstrb_i[i/8];
            end
        end
        awready_nxt = ~aw_have_nxt;
        wready_nxt = ~w_have_nxt;
        bvalid_nxt = wr_fire | (bvalid_r & ~s_axi_bready_i);
        bresp_nxt = wr_fire ? (wr_known ? AXI_RESP_OKAY : AXI_RESP_SLVERR) : bresp_r;
        rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready_i);
        arready_nxt = ~rvalid_nxt;
        rresp_nxt = ar_take ? (rd_known ? AXI_RESP_OKAY : AXI_RESP_SLVERR) : rresp_r;
        rdata_nxt = rdata_r;
        if (ar_take) begin
            rdata_nxt = '0;
            // [RULE17] alias addresses read as zero
            if (rd_op == OP_WRITE && rd_known) begin
                case (rd_base)
                    OFF_ANALOG_SELECT: rdata_nxt[W-1:0] = ansel_r;
                    OFF_PIN_DIRECTION: rdata_nxt[W-1:0] = dir_r;
                    OFF_PIN_LEVEL: rdata_nxt[W-1:0] = pin_level;
                    // [RULE3] latch reads the latch
                    OFF_OUTPUT_LATCH: rdata_nxt[W-1:0] = lat_r;
                    OFF_OPEN_DRAIN: rdata_nxt[W-1:0] = odc_r;
                    OFF_PULLUP_EN: rdata_nxt[W-1:0] = pu_r;
                    OFF_PULLDOWN_EN: rdata_nxt[W-1:0] = pd_r;
                    OFF_CHANGE_CTRL: rdata_nxt[CHANGE_CTRL_ON_BIT] = cn_on_r;
                    OFF_CHANGE_IRQ_EN: rdata_nxt[W-1:0] = cnen_r;
                    OFF_CHANGE_STATUS: rdata_nxt[W-1:0] = cnstat_r;
                    OFF_REMAP_ENABLE: rdata_nxt[W-1:0] = remap_en_r;
                    default: rdata_nxt = '0;
                endcase
            end
        end
    end
    // register writes
    always_comb begin
        ansel_nxt = ansel_r;
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        odc_nxt = odc_r;
        pu_nxt = pu_r;
        pd_nxt = pd_r;
        cnen_nxt = cnen_r;
        cn_on_nxt = cn_on_r;
        remap_en_nxt = remap_en_r;
        cl_val = '0;
        if (wr_fire && wr_known) begin
            // [RULE16] alias ops modify only bits written as one
            case (wr_base)
                OFF_ANALOG_SELECT: ansel_nxt = apply_op(ansel_r, wr_op, wval, wmask_r);
                // [RULE1] direction bit written by software
                OFF_PIN_DIRECTION: dir_nxt = apply_op(dir_r, wr_op, wval, wmask_r);
                // [RULE4] level register writes land in the latch
                OFF_PIN_LEVEL: lat_nxt = apply_op(lat_r, wr_op, wval, wmask_r);
                // [RULE3] latch write
                OFF_OUTPUT_LATCH: lat_nxt = apply_op(lat_r, wr_op, wval, wmask_r);
                OFF_OPEN_DRAIN: odc_nxt = apply_op(odc_r, wr_op, wval, wmask_r);
                // [RULE14] independent pull enables
                OFF_PULLUP_EN: pu_nxt = apply_op(pu_r, wr_op, wval, wmask_r);
                OFF_PULLDOWN_EN: pd_nxt = apply_op(pd_r, wr_op, wval, wmask_r);
                OFF_CHANGE_CTRL: begin
                    cl_val[CHANGE_CTRL_ON_BIT] = cn_on_r;
                    cl_val = apply_op(cl_val, wr_op, wval, wmask_r);
                    cn_on_nxt = cl_val[CHANGE_CTRL_ON_BIT];
                end
                OFF_CHANGE_IRQ_EN: cnen_nxt = apply_op(cnen_r, wr_op, wval, wmask_r);
                OFF_REMAP_ENABLE: remap_en_nxt = apply_op(remap_en_r, wr_op, wval, wmask_r);
                default: cl_val = '0;
            endcase
        end
    end
    // change notification
    always_comb begin
        // [RULE13] set on change, cleared by a level-register read, set wins
        cnstat_nxt = cnstat_r;
        if (ar_take && rd_known && rd_base == OFF_PIN_LEVEL && rd_op == OP_WRITE) begin
            cnstat_nxt = '0;
        end
        // [RULE11] [RULE12] enabled change, gated only by the on bit, never by sleep
        cnstat_nxt = cnstat_nxt | (sync.chg & cnen_r & {W{cn_on_r}});
        // [RULE21] one request from any flagged and enabled pin
        irq_nxt = |(cnstat_r & cnen_r);
    end
    // pin drivers
    always_comb begin
        // [RULE19] [RULE20] remap wins, never over analog
        remap_use = remap_en_r & remap_active_i & ~ansel_r;
        // [RULE9] analog select does not stop digital drive
        gpio_oe_n = dir_r;
        pin_out_nxt = (remap_use & remap_out_i) | (~remap_use & lat_r);
        // [RULE1] drive when direction bit is zero
        oe_n_nxt = (remap_use & ~remap_drive_i) | (~remap_use & gpio_oe_n);
        // [RULE5] open drain releases instead of driving high
        oe_n_nxt = oe_n_nxt | (odc_r & pin_out_nxt);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // [RULE2] all pins inputs
            dir_r <= {W{DIR_RST_BIT}};
            // [RULE6] analog mode by default
            ansel_r <= {W{ANSEL_RST_BIT}};
            lat_r <= {W{LATCH_RST_BIT}};
            odc_r <= {W{CFG_RST_BIT}};
            pu_r <= {W{CFG_RST_BIT}};
            pd_r <= {W{CFG_RST_BIT}};
            cnen_r <= {W{CFG_RST_BIT}};
            cnstat_r <= {W{CFG_RST_BIT}};
            // [RULE18] remap starts disconnected
            remap_en_r <= {W{REMAP_RST_BIT}};
            cn_on_r <= CHANGE_ON_RST;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= '0;
            wdata_r <= '0;
            wmask_r <= '0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= AXI_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= AXI_RESP_OKAY;
            rdata_r <= '0;
            pin_out_r <= '0;
            oe_n_r <= '1;
            irq_r <= 1'b0;
        end else begin
            dir_r <= dir_nxt;
            ansel_r <= ansel_nxt;
            lat_r <= lat_nxt;
            odc_r <= odc_nxt;
            pu_r <= pu_nxt;
            pd_r <= pd_nxt;
            cnen_r <= cnen_nxt;
            cnstat_r <= cnstat_nxt;
            remap_en_r <= remap_en_nxt;
            cn_on_r <= cn_on_nxt;
            aw_have_r <= aw_have_nxt;
            w_have_r <= w_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            wdata_r <= wdata_nxt;
            wmask_r <= wmask_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            pin_out_r <= pin_out_nxt;
            oe_n_r <= oe_n_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o = wready_r;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rresp_o = rresp_r;
    assign s_axi_rdata_o = rdata_r;
    assign pin_out_o = pin_out_r;
    assign pin_oe_n_o = oe_n_r;
    assign weak_pullup_en_o = pu_r;
    assign weak_pulldown_en_o = pd_r;
    assign change_irq_o = irq_r;
    // checks; helper flags only the assertions and covers read
    logic rd_port_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rd_port_r <= 1'b0;
        end else if (ar_take) begin
            rd_port_r <= (rd_base == OFF_PIN_LEVEL) && (rd_op == OP_WRITE);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reset_inputs_a: assert property ($past(rst_i) |-> dir_r == '1 && (&oe_n_r)) // [RULE2]
        else $error("pins not inputs after reset");
    reset_analog_a: assert property ($past(rst_i) |-> ansel_r == '1) // [RULE6]
        else $error("analog select not all ones after reset");
    input_undriven_a: assert property ( // [RULE1]
        ((dir_r & ~(remap_en_r & remap_active_i & ~ansel_r)) == '1) |=> (&pin_oe_n_o))
        else $error("input pin driven");
    open_drain_a: assert property (((~pin_oe_n_o) & pin_out_o & $past(odc_r)) == '0) // [RULE5]
        else $error("open drain pin driven high");
    analog_read_a: assert property ( // [RULE8]
        $rose(s_axi_rvalid_o) && rd_port_r |-> (s_axi_rdata_o[W-1:0] & $past(ana_in)) == '0)
        else $error("analog input read non-zero");
    change_capture_a: assert property ( // [RULE13]
        (|(sync.chg & cnen_r)) && cn_on_r |=> (cnstat_r & $past(sync.chg & cnen_r)) != '0)
        else $error("enabled change not captured");
    irq_raise_a: assert property ((|(cnstat_r & cnen_r)) |=> change_irq_o) // [RULE21]
        else $error("change request missing");
    alias_set_a: assert property ( // [RULE16]
        wr_fire && wr_known && wr_base == OFF_OUTPUT_LATCH && wr_op == OP_SET
        |=> (lat_r & $past(wval & wmask_r)) == $past(wval & wmask_r)
            && (lat_r & ~$past(wval & wmask_r)) == ($past(lat_r) & ~$past(wval & wmask_r)))
        else $error("set alias touched wrong bits");
    remap_default_a: assert property ($past(rst_i) |-> remap_en_r == '0) // [RULE18]
        else $error("remap connected after reset");
    analog_priority_a: assert property ( // [RULE20]
        ((pin_oe_n_o ^ $past(gpio_oe_n | (odc_r & lat_r))) & $past(ansel_r)) == '0)
        else $error("remap overrode analog pin");
    latch_write_a: assert property ( // [RULE3]
        wr_fire && wr_known && wr_op == OP_WRITE && wr_base == OFF_OUTPUT_LATCH
        |=> lat_r == (($past(lat_r) & ~$past(wmask_r)) | $past(wval & wmask_r)))
        else $error("latch write lost");
    write_cov_c: cover property (wr_fire ##1 s_axi_bvalid_o && s_axi_bready_i);
    port_read_c: cover property ($rose(s_axi_rvalid_o) && rd_port_r && cnstat_r == '0);
    irq_rise_c: cover property ($rose(change_irq_o));
    remap_c: cover property (|(remap_en_r & remap_active_i & ~ansel_r));
endmodule : gpcn_top

/* sim/gpcn_pin_model.sv */
module gpcn_pin_model
    import gpcn_pkg::*;
#(
    parameter int W = GPCN_WIDTH
) (
    input wire logic clk_i,
    input wire logic [W-1:0] pin_out_i,
    input wire logic [W-1:0] oe_n_i,
    input wire logic [W-1:0] pullup_i,
    input wire logic [W-1:0] pulldown_i,
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    output logic [W-1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [W-1:0] last_r = '0;
    // a floating pin wanders, so a stale level never passes for a real one
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (!oe_n_i[i]) level_o[i] = pin_out_i[i];
            else if (ext_en_i[i]) level_o[i] = ext_val_i[i];
            else if (pullup_i[i]) level_o[i] = 1'b1;
            else if (pulldown_i[i]) level_o[i] = 1'b0;
            else level_o[i] = ~last_r[i];
        end
    end
    always_ff @(posedge clk_i) begin
        last_r <= level_o;
    end
endmodule : gpcn_pin_model

/* sim/gpio_port_with_change_notify_tb_top.sv */
module gpio_port_with_change_notify_tb_top
    import gpcn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [15:0] ract = '0, rout = '0, rdrv = '0, ext_en = '0, ext_val = '0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    logic [15:0] pin_out, oe_n, pu, pd, lvl;
    int fails = 0, checked = 0;

    always #20 clk_i = ~clk_i;

    gpcn_top DUT (
        .clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .pin_in_i(lvl), .pin_out_o(pin_out), .pin_oe_n_o(oe_n),
        .weak_pullup_en_o(pu), .weak_pulldown_en_o(pd),
        .remap_active_i(ract), .remap_out_i(rout), .remap_drive_i(rdrv),
        .change_irq_o(irq)
    );

    gpcn_pin_model u_pins (
        .clk_i(clk_i), .pin_out_i(pin_out), .oe_n_i(oe_n), .pullup_i(pu),
        .pulldown_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(lvl)
    );

    task automatic report_and_stop;
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge clk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        if (n == 50) chk("bvalid", 32'h1, 32'h0);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        if (n == 50) chk("rvalid", 32'h1, 32'h0);
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        rd(a);
        chk(nm, exp, d);
        chk("rresp", {30'h0, AXI_RESP_OKAY}, {30'h0, r});
    endtask : rchk

    task automatic wait_irq;
        int n;
        for (n = 0; n < 10 && irq !== 1'b1; n++) @(posedge clk_i);
        chk("irq", 32'h1, {31'h0, irq});
    endtask : wait_irq

    task automatic t_reset;
        chk("oe_n", 32'h0000_ffff, {16'h0, oe_n});
        rchk(OFF_PIN_DIRECTION, 32'h0000_ffff, "dir");
        rchk(OFF_ANALOG_SELECT, 32'h0000_ffff, "ansel");
        rchk(OFF_OUTPUT_LATCH, 32'h0, "latch");
    endtask : t_reset

    task automatic t_latch;
        wr(OFF_ANALOG_SELECT, 32'h0, AXI_RESP_OKAY);
        wr(OFF_PIN_DIRECTION, 32'h0, AXI_RESP_OKAY);
        wr(OFF_OUTPUT_LATCH, 32'hffff_5a5a, AXI_RESP_OKAY);
        rchk(OFF_OUTPUT_LATCH, 32'h0000_5a5a, "latch");
        chk("oe_n", 32'h0, {16'h0, oe_n});
        chk("pin_out", 32'h0000_5a5a, {16'h0, pin_out});
        wr(OFF_PIN_LEVEL, 32'h0000_1234, AXI_RESP_OKAY);
        // settle time before reading the port back
        repeat (3) @(posedge clk_i);
        rchk(OFF_OUTPUT_LATCH, 32'h0000_1234, "latch");
        rchk(OFF_PIN_LEVEL, 32'h0000_1234, "level");
    endtask : t_latch

    task automatic t_alias;
        wr(OFF_OUTPUT_LATCH + 8'h04, 32'h0000_00f0, AXI_RESP_OKAY);
        rchk(OFF_OUTPUT_LATCH, 32'h0000_1204, "clr");
        wr(OFF_OUTPUT_LATCH + 8'h08, 32'h0000_000f, AXI_RESP_OKAY);
        rchk(OFF_OUTPUT_LATCH, 32'h0000_120f, "set");
        wr(OFF_OUTPUT_LATCH + 8'h0c, 32'h0000_ff00, AXI_RESP_OKAY);
        rchk(OFF_OUTPUT_LATCH, 32'h0000_ed0f, "inv");
    endtask : t_alias

    task automatic t_drain_pull;
        wr(OFF_OPEN_DRAIN, 32'h0000_00ff, AXI_RESP_OKAY);
        wr(OFF_PULLUP_EN, 32'h0000_000f, AXI_RESP_OKAY);
        wr(OFF_PULLDOWN_EN, 32'h0000_0f00, AXI_RESP_OKAY);
        chk("oe_n", 32'h0000_000f, {16'h0, oe_n});
        chk("pin_out", 32'h0000_ed00, {16'h0, pin_out & ~oe_n});
        chk("pulls", 32'h0f00_000f, {pd, pu});
        repeat (3) @(posedge clk_i);
        rchk(OFF_PIN_LEVEL, 32'h0000_ed0f, "level");
        // pulls off again for driven pins
        wr(OFF_PULLUP_EN, 32'h0, AXI_RESP_OKAY);
        wr(OFF_PULLDOWN_EN, 32'h0, AXI_RESP_OKAY);
        wr(OFF_OPEN_DRAIN, 32'h0, AXI_RESP_OKAY);
    endtask : t_drain_pull

    task automatic t_analog;
        wr(OFF_ANALOG_SELECT, 32'h0000_ffff, AXI_RESP_OKAY);
        chk("oe_n", 32'h0, {16'h0, oe_n});
        chk("pin_out", 32'h0000_ed0f, {16'h0, pin_out});
        wr(OFF_PIN_DIRECTION, 32'h0000_ffff, AXI_RESP_OKAY);
        ext_en <= 16'hffff;
        ext_val <= 16'hffff;
        repeat (3) @(posedge clk_i);
        rchk(OFF_PIN_LEVEL, 32'h0, "level");
        wr(OFF_ANALOG_SELECT, 32'h0000_00ff, AXI_RESP_OKAY);
        repeat (3) @(posedge clk_i);
        rchk(OFF_PIN_LEVEL, 32'h0000_ff00, "level");
        wr(OFF_ANALOG_SELECT, 32'h0, AXI_RESP_OKAY);
    endtask : t_analog

    task automatic t_change;
        ext_val <= 16'h0;
        repeat (4) @(posedge clk_i);
        rchk(OFF_PIN_LEVEL, 32'h0, "level");
        wr(OFF_CHANGE_IRQ_EN, 32'h0000_0008, AXI_RESP_OKAY);
        chk("irq", 32'h0, {31'h0, irq});
        ext_val <= 16'h0018;
        wait_irq();
        rchk(OFF_CHANGE_STATUS, 32'h0000_0008, "status");
        rchk(OFF_PIN_LEVEL, 32'h0000_0018, "level");
        repeat (3) @(posedge clk_i);
        chk("irq", 32'h0, {31'h0, irq});
        rchk(OFF_CHANGE_STATUS, 32'h0, "status");
        // falling edge counts as a change too
        ext_val <= 16'h0010;
        wait_irq();
        rchk(OFF_PIN_LEVEL, 32'h0000_0010, "level");
        // with the on bit cleared no change is captured
        rchk(OFF_CHANGE_CTRL, 32'h0000_8000, "cn_on");
        wr(OFF_CHANGE_CTRL, 32'h0, AXI_RESP_OKAY);
        ext_val <= 16'h0018;
        repeat (6) @(posedge clk_i);
        rchk(OFF_CHANGE_STATUS, 32'h0, "status off");
        chk("irq", 32'h0, {31'h0, irq});
    endtask : t_change

    task automatic t_remap;
        ext_en <= 16'h0;
        ract <= 16'h0007;
        rdrv <= 16'h0007;
        rout <= 16'h0005;
        repeat (2) @(posedge clk_i);
        chk("oe_n", 32'h7, {29'h0, oe_n[2:0]});
        wr(OFF_REMAP_ENABLE, 32'h0000_0003, AXI_RESP_OKAY);
        repeat (2) @(posedge clk_i);
        chk("oe_n", 32'h4, {29'h0, oe_n[2:0]});
        chk("pin_out", 32'h1, {30'h0, pin_out[1:0]});
        wr(OFF_ANALOG_SELECT + 8'h08, 32'h0000_0002, AXI_RESP_OKAY);
        repeat (2) @(posedge clk_i);
        chk("oe_n", 32'h6, {29'h0, oe_n[2:0]});
    endtask : t_remap

    task automatic t_unmapped;
        rd(8'hb0);
        chk("rresp", {30'h0, AXI_RESP_SLVERR}, {30'h0, r});
        chk("rdata", 32'h0, d);
        wr(8'h32, 32'h0000_ffff, AXI_RESP_SLVERR);
        rchk(OFF_OUTPUT_LATCH, 32'h0000_ed0f, "latch");
    endtask : t_unmapped

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_latch();
        t_alias();
        t_drain_pull();
        t_analog();
        t_change();
        t_remap();
        t_unmapped();
        report_and_stop();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        report_and_stop();
    end
endmodule : gpio_port_with_change_notify_tb_top
